//--- src/mpu_config.sv
// Configuration objects for homing ramp, jerk, unit descriptors, position offset.
// Assumes a host object port (index/subindex, one-cycle strobes) on core_clk;
// homing switch and end inputs come from pins and are synchronised here.
`timescale 1ns/1ps
module mpu_config
   import mpu_pkg::*;
#(
   parameter int NUM_JERK = 4
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [15:0] obj_index,
   input wire logic [7:0] obj_sub,
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [31:0] obj_wdata,
   output logic [31:0] obj_rdata,
   output logic obj_ack,
   output logic obj_err,
   input wire logic [31:0] op_mode,
   input wire logic [31:0] pos_setpoint_in,
   output logic [31:0] pos_setpoint_out,
   input wire logic [1:0] jerk_segment,
   output logic [31:0] jerk_active,
   output logic jerk_unlimited,
   output logic [31:0] jerk_num,
   output logic [31:0] jerk_div,
   output logic [7:0] pos_unit_code,
   output logic [7:0] pos_unit_exp,
   output logic [7:0] vel_time_unit,
   output logic [7:0] vel_pos_unit,
   output logic [7:0] vel_unit_exp,
   input wire logic homing_start,
   input wire logic homing_switch_pin,
   input wire logic homing_end_pin,
   output logic [31:0] homing_speed_cmd,
   output logic [31:0] homing_accel_cmd,
   output logic homing_ramp_en,
   output logic homing_busy
);
   // Segment decode and port width assume exactly four limits
   if (NUM_JERK != 4) begin
      $error("jerk limit count must be four");
   end

   logic [31:0] homing_ramp_accel_q;
   logic [31:0] speed_switch_q;
   logic [31:0] speed_zero_q;
   logic [31:0] jerk_num_q;
   logic [31:0] jerk_div_q;
   logic [31:0] jerk_limits_q [NUM_JERK];
   logic [31:0] position_unit_descriptor_q;
   logic [31:0] velocity_unit_descriptor_q;
   logic [31:0] setpoint_position_offset_q;
   logic [31:0] pos_setpoint_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic err_q;
   logic [1:0] sw_sync_q;
   logic [1:0] end_sync_q;
   logic hit_d;
   logic [31:0] rd_d;

   function automatic logic is_obj(input logic [15:0] idx, input logic [7:0] sub,
                                   input logic [15:0] want_idx, input logic [7:0] want_sub);
      is_obj = (idx == want_idx) && (sub == want_sub);
   endfunction

   // Two-flop synchronisers for the homing sensor pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sw_sync_q <= 2'b00;
         end_sync_q <= 2'b00;
      end else begin
         sw_sync_q <= {sw_sync_q[0], homing_switch_pin};
         end_sync_q <= {end_sync_q[0], homing_end_pin};
      end
   end

   // Object writes; speed ordering left to the host
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         homing_ramp_accel_q <= RST_HOMING_ACCEL;
         speed_switch_q <= RST_SPEED_SWITCH;
         speed_zero_q <= RST_SPEED_ZERO;
         jerk_num_q <= RST_JERK_FACTOR;
         jerk_div_q <= RST_JERK_FACTOR;
         for (int i = 0; i < NUM_JERK; i++) jerk_limits_q[i] <= RST_JERK_LIMIT;
         position_unit_descriptor_q <= RST_POS_UNIT;
         velocity_unit_descriptor_q <= RST_VEL_UNIT;
         setpoint_position_offset_q <= RST_POS_OFFSET;
      end else if (obj_wr) begin
         if (is_obj(obj_index, obj_sub, IDX_HOMING_ACCEL, SUB_COUNT)) homing_ramp_accel_q <= obj_wdata;
         if (is_obj(obj_index, obj_sub, IDX_HOMING_SPEED, SUB_ONE)) speed_switch_q <= obj_wdata;
         if (is_obj(obj_index, obj_sub, IDX_HOMING_SPEED, SUB_TWO)) speed_zero_q <= obj_wdata;
         if (is_obj(obj_index, obj_sub, IDX_JERK_FACTOR, SUB_ONE)) jerk_num_q <= obj_wdata;
         if (is_obj(obj_index, obj_sub, IDX_JERK_FACTOR, SUB_TWO)) jerk_div_q <= obj_wdata;
         if (obj_index == IDX_JERK_LIMITS && obj_sub >= SUB_ONE && obj_sub <= SUB_FOUR) begin
            jerk_limits_q[obj_sub[1:0] - 2'd1] <= obj_wdata;
         end
         if (is_obj(obj_index, obj_sub, IDX_POS_UNIT, SUB_COUNT)) begin
            position_unit_descriptor_q <= obj_wdata & MASK_POS_UNIT;
         end
         if (is_obj(obj_index, obj_sub, IDX_VEL_UNIT, SUB_COUNT)) begin
            velocity_unit_descriptor_q <= obj_wdata & MASK_VEL_UNIT;
         end
         if (is_obj(obj_index, obj_sub, IDX_POS_OFFSET, SUB_COUNT)) setpoint_position_offset_q <= obj_wdata;
      end
   end

   // Read decode; subindex 0 of arrays reports entry count
   always_comb begin
      hit_d = 1'b1;
      rd_d = ZERO_WORD;
      if (is_obj(obj_index, obj_sub, IDX_HOMING_ACCEL, SUB_COUNT)) rd_d = homing_ramp_accel_q;
      else if (is_obj(obj_index, obj_sub, IDX_HOMING_SPEED, SUB_COUNT)) rd_d = {24'h000000, NUM_SPEED_SUBS};
      else if (is_obj(obj_index, obj_sub, IDX_HOMING_SPEED, SUB_ONE)) rd_d = speed_switch_q;
      else if (is_obj(obj_index, obj_sub, IDX_HOMING_SPEED, SUB_TWO)) rd_d = speed_zero_q;
      else if (is_obj(obj_index, obj_sub, IDX_JERK_FACTOR, SUB_COUNT)) rd_d = {24'h000000, NUM_FACTOR_SUBS};
      else if (is_obj(obj_index, obj_sub, IDX_JERK_FACTOR, SUB_ONE)) rd_d = jerk_num_q;
      else if (is_obj(obj_index, obj_sub, IDX_JERK_FACTOR, SUB_TWO)) rd_d = jerk_div_q;
      else if (is_obj(obj_index, obj_sub, IDX_JERK_LIMITS, SUB_COUNT)) rd_d = {24'h000000, NUM_JERK_SUBS};
      else if (obj_index == IDX_JERK_LIMITS && obj_sub >= SUB_ONE && obj_sub <= SUB_FOUR) begin
         rd_d = jerk_limits_q[obj_sub[1:0] - 2'd1];
      end
      else if (is_obj(obj_index, obj_sub, IDX_POS_UNIT, SUB_COUNT)) rd_d = position_unit_descriptor_q;
      else if (is_obj(obj_index, obj_sub, IDX_VEL_UNIT, SUB_COUNT)) rd_d = velocity_unit_descriptor_q;
      else if (is_obj(obj_index, obj_sub, IDX_POS_OFFSET, SUB_COUNT)) rd_d = setpoint_position_offset_q;
      else hit_d = 1'b0;
   end

   // Writes to subindex 0 of arrays are refused; they are read-only counts
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= ZERO_WORD;
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ack_q <= obj_wr || obj_rd;
         err_q <= (obj_wr || obj_rd) && (!hit_d || (obj_wr && obj_sub == SUB_COUNT &&
                  (obj_index == IDX_HOMING_SPEED || obj_index == IDX_JERK_FACTOR || obj_index == IDX_JERK_LIMITS)));
         if (obj_rd) rdata_q <= rd_d;
      end
   end

   // Offset only counts in the modes that follow an external position stream
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pos_setpoint_q <= ZERO_WORD;
      end else if (op_mode == MODE_CSP || op_mode == MODE_CLKDIR) begin
         pos_setpoint_q <= pos_setpoint_in + setpoint_position_offset_q;
      end else begin
         pos_setpoint_q <= pos_setpoint_in;
      end
   end

   // Segment select: 0 acc begin, 1 acc end, 3 dec begin, 2 dec end
   always_comb begin
      unique case (mpu_seg_type'(jerk_segment))
         MPU_SEG_ACC_BEGIN: jerk_active = jerk_limits_q[0];
         MPU_SEG_ACC_END: jerk_active = jerk_limits_q[2];
         MPU_SEG_DEC_BEGIN: jerk_active = jerk_limits_q[1];
         MPU_SEG_DEC_END: jerk_active = jerk_limits_q[3];
      endcase
   end
   assign jerk_unlimited = jerk_active == JERK_UNLIMITED;

   assign obj_rdata = rdata_q;
   assign obj_ack = ack_q;
   assign obj_err = err_q;
   assign pos_setpoint_out = pos_setpoint_q;
   assign jerk_num = jerk_num_q;
   assign jerk_div = jerk_div_q;
   assign pos_unit_code = position_unit_descriptor_q[23:16];
   assign pos_unit_exp = position_unit_descriptor_q[31:24];
   assign vel_time_unit = velocity_unit_descriptor_q[15:8];
   assign vel_pos_unit = velocity_unit_descriptor_q[23:16];
   assign vel_unit_exp = velocity_unit_descriptor_q[31:24];

   mpu_homing_seq u_home (
      .core_clk(core_clk),
      .resetn(resetn),
      .start(homing_start),
      .switch_hit(sw_sync_q[1]),
      .end_hit(end_sync_q[1]),
      .speed_switch(speed_switch_q),
      .speed_zero(speed_zero_q),
      .accel(homing_ramp_accel_q),
      .speed_cmd(homing_speed_cmd),
      .accel_cmd(homing_accel_cmd),
      .ramp_en(homing_ramp_en),
      .busy(homing_busy)
   );

   property p_unit_reserved;
      @(posedge core_clk) disable iff (!resetn)
      (position_unit_descriptor_q[15:0] == 16'h0000) && (velocity_unit_descriptor_q[7:0] == 8'h00);
   endproperty
   a_unit_reserved: assert property (p_unit_reserved) else $error("reserved unit bits nonzero");

   property p_offset_mode;
      @(posedge core_clk) disable iff (!resetn)
      (op_mode != MODE_CSP && op_mode != MODE_CLKDIR) |=> pos_setpoint_out == $past(pos_setpoint_in);
   endproperty
   a_offset_mode: assert property (p_offset_mode) else $error("offset applied outside its modes");

   property p_offset_add;
      @(posedge core_clk) disable iff (!resetn)
      (op_mode == MODE_CSP && !obj_wr) |=> pos_setpoint_out == $past(pos_setpoint_in) + setpoint_position_offset_q;
   endproperty
   a_offset_add: assert property (p_offset_add) else $error("offset not added in CSP");

   property p_jerk_zero;
      @(posedge core_clk) disable iff (!resetn)
      (jerk_segment == 2'b11) |-> jerk_unlimited == (jerk_limits_q[1] == JERK_UNLIMITED);
   endproperty
   a_jerk_zero: assert property (p_jerk_zero) else $error("unlimited flag wrong");

   property p_dec_begin;
      @(posedge core_clk) disable iff (!resetn)
      jerk_segment == 2'b11 |-> jerk_active == jerk_limits_q[1];
   endproperty
   a_dec_begin: assert property (p_dec_begin) else $error("braking start jerk wrong");

   property p_accel_write;
      @(posedge core_clk) disable iff (!resetn)
      (obj_wr && obj_index == IDX_HOMING_ACCEL && obj_sub == SUB_COUNT) |=> homing_ramp_accel_q == $past(obj_wdata);
   endproperty
   a_accel_write: assert property (p_accel_write) else $error("homing accel not stored");

   property p_factor_read;
      @(posedge core_clk) disable iff (!resetn)
      (obj_rd && obj_index == IDX_JERK_FACTOR && obj_sub == SUB_TWO && !obj_wr) |=> obj_rdata == jerk_div_q && obj_ack;
   endproperty
   a_factor_read: assert property (p_factor_read) else $error("jerk divisor readback wrong");

   property p_pos_fields;
      @(posedge core_clk) disable iff (!resetn)
      (obj_wr && obj_index == IDX_POS_UNIT && obj_sub == SUB_COUNT) |=> pos_unit_code == $past(obj_wdata[23:16]);
   endproperty
   a_pos_fields: assert property (p_pos_fields) else $error("position unit field wrong");
endmodule

//--- src/mpu_pkg.sv
// Shared constants for the motion profile unit configuration block.
// Assumes object-dictionary style access: index plus subindex, 32-bit data.
package mpu_pkg;
   localparam logic [15:0] IDX_HOMING_ACCEL = 16'h609A;
   localparam logic [15:0] IDX_HOMING_SPEED = 16'h6099;
   localparam logic [15:0] IDX_JERK_FACTOR = 16'h60A2;
   localparam logic [15:0] IDX_JERK_LIMITS = 16'h60A4;
   localparam logic [15:0] IDX_POS_UNIT = 16'h60A8;
   localparam logic [15:0] IDX_VEL_UNIT = 16'h60A9;
   localparam logic [15:0] IDX_POS_OFFSET = 16'h60B0;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_ONE = 8'h01;
   localparam logic [7:0] SUB_TWO = 8'h02;
   localparam logic [7:0] SUB_THREE = 8'h03;
   localparam logic [7:0] SUB_FOUR = 8'h04;
   localparam logic [7:0] NUM_SPEED_SUBS = 8'h02;
   localparam logic [7:0] NUM_FACTOR_SUBS = 8'h02;
   localparam logic [7:0] NUM_JERK_SUBS = 8'h04;
   localparam logic [31:0] RST_HOMING_ACCEL = 32'h000001F4;
   localparam logic [31:0] RST_SPEED_SWITCH = 32'h00000032;
   localparam logic [31:0] RST_SPEED_ZERO = 32'h0000000A;
   localparam logic [31:0] RST_JERK_FACTOR = 32'h00000001;
   localparam logic [31:0] RST_JERK_LIMIT = 32'h000003E8;
   localparam logic [31:0] RST_POS_UNIT = 32'hFF410000;
   localparam logic [31:0] RST_VEL_UNIT = 32'h00B44700;
   localparam logic [31:0] RST_POS_OFFSET = 32'h00000000;
   localparam logic [31:0] MASK_POS_UNIT = 32'hFFFF0000;
   localparam logic [31:0] MASK_VEL_UNIT = 32'hFFFFFF00;
   localparam logic [31:0] JERK_UNLIMITED = 32'h00000000;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [31:0] MODE_CSP = 32'h00000008;
   localparam logic [31:0] MODE_CLKDIR = 32'hFFFFFF9C;
   typedef enum logic [1:0] {
      MPU_IDLE = 2'b00,
      MPU_ACCEL = 2'b01,
      MPU_SEARCH_SW = 2'b11,
      MPU_SEARCH_REF = 2'b10
   } mpu_home_type;
   typedef enum logic [1:0] {
      MPU_SEG_ACC_BEGIN = 2'b00,
      MPU_SEG_ACC_END = 2'b01,
      MPU_SEG_DEC_BEGIN = 2'b11,
      MPU_SEG_DEC_END = 2'b10
   } mpu_seg_type;
endpackage

//--- src/mpu_homing_seq.sv
// Homing speed sequencer: start ramp, switch speed drop, stop at end position.
// Assumes switch and end inputs are already synchronised to core_clk.
`timescale 1ns/1ps
module mpu_homing_seq
   import mpu_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic switch_hit,
   input wire logic end_hit,
   input wire logic [31:0] speed_switch,
   input wire logic [31:0] speed_zero,
   input wire logic [31:0] accel,
   output logic [31:0] speed_cmd,
   output logic [31:0] accel_cmd,
   output logic ramp_en,
   output logic busy
);
   mpu_home_type state_q;
   logic [31:0] speed_q;
   logic [31:0] accel_q;
   logic ramp_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= MPU_IDLE;
      end else begin
         unique case (state_q)
            MPU_IDLE: if (start) state_q <= MPU_ACCEL;
            MPU_ACCEL: state_q <= end_hit ? MPU_IDLE : (switch_hit ? MPU_SEARCH_REF : MPU_SEARCH_SW);
            MPU_SEARCH_SW: state_q <= end_hit ? MPU_IDLE : (switch_hit ? MPU_SEARCH_REF : MPU_SEARCH_SW);
            MPU_SEARCH_REF: if (end_hit) state_q <= MPU_IDLE;
         endcase
      end
   end

   // Outputs registered so drive changes land one cycle after the event
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         speed_q <= ZERO_WORD;
         accel_q <= ZERO_WORD;
         ramp_q <= 1'b0;
      end else if (end_hit && state_q != MPU_IDLE) begin
         speed_q <= ZERO_WORD;
         ramp_q <= 1'b0;
      end else if (switch_hit && (state_q == MPU_ACCEL || state_q == MPU_SEARCH_SW)) begin
         speed_q <= speed_zero;
         ramp_q <= 1'b0;
      end else if (state_q == MPU_IDLE && start) begin
         speed_q <= speed_switch;
         accel_q <= accel;
         ramp_q <= 1'b1;
      end else if (state_q != MPU_IDLE) begin
         ramp_q <= 1'b0;
      end
   end

   assign speed_cmd = speed_q;
   assign accel_cmd = accel_q;
   assign ramp_en = ramp_q;
   assign busy = state_q != MPU_IDLE;

   property p_switch_no_ramp;
      @(posedge core_clk) disable iff (!resetn)
      (switch_hit && !end_hit && state_q == MPU_SEARCH_SW) |=> (speed_cmd == $past(speed_zero)) && !ramp_en;
   endproperty
   a_switch_no_ramp: assert property (p_switch_no_ramp) else $error("switch did not drop speed");

   property p_end_stop;
      @(posedge core_clk) disable iff (!resetn)
      (end_hit && state_q != MPU_IDLE) |=> (speed_cmd == ZERO_WORD) && !ramp_en && !busy;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("end position did not stop");

   sequence s_started;
      state_q == MPU_IDLE && start && !end_hit && !switch_hit;
   endsequence
   property p_ramp_once;
      @(posedge core_clk) disable iff (!resetn)
      s_started |=> ramp_en ##1 !ramp_en;
   endproperty
   a_ramp_once: assert property (p_ramp_once) else $error("ramp not confined to start");
endmodule

//--- tb/mpu_host_model.sv
// Host side of the object port: issues one read or write per call.
// Assumes a single caller; requests start and end on falling edges.
`timescale 1ns/1ps
module mpu_host_model (
   input wire logic core_clk,
   output logic [15:0] obj_index,
   output logic [7:0] obj_sub,
   output logic obj_wr,
   output logic obj_rd,
   output logic [31:0] obj_wdata,
   input wire logic [31:0] obj_rdata,
   input wire logic obj_ack,
   input wire logic obj_err
);
   initial begin
      obj_index = 16'h0000;
      obj_sub = 8'h00;
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_wdata = 32'h00000000;
   end
   // Gap cycles let a caller pace requests slowly; with gap 0 one idle cycle still separates them
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] data, input int gap, output logic [31:0] rdata, output logic ack,
      output logic err);
      repeat (gap) @(negedge core_clk);
      @(negedge core_clk);
      obj_index = idx;
      obj_sub = sub;
      obj_wr = wr;
      obj_rd = !wr;
      obj_wdata = wr ? data : ~obj_wdata;
      @(negedge core_clk);
      rdata = obj_rdata;
      ack = obj_ack;
      err = obj_err;
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      // Released lines toggle so stale values never look valid
      obj_wdata = ~obj_wdata;
      obj_index = ~idx;
      obj_sub = ~sub;
   endtask
endmodule

//--- tb/motion_profile_unit_config_tb_top.sv
// Self-checking bench for the configuration block and homing sequencer.
// Assumes the host model drives the object port; pins driven directly.
`timescale 1ns/1ps
module motion_profile_unit_config_tb_top;
   import mpu_pkg::*;
   typedef struct packed {
      logic wr;
      logic [15:0] idx;
      logic [7:0] sub;
      logic [31:0] wd;
      logic [31:0] rd;
      logic err;
   } mpu_row_type;
   logic core_clk, resetn, obj_wr, obj_rd, obj_ack, obj_err, jerk_unlimited;
   logic homing_start, homing_switch_pin, homing_end_pin, homing_ramp_en, homing_busy, ack, err;
   logic [15:0] obj_index;
   logic [7:0] obj_sub, pos_unit_code, pos_unit_exp, vel_time_unit, vel_pos_unit, vel_unit_exp;
   logic [31:0] obj_wdata, obj_rdata, op_mode, pos_setpoint_in, pos_setpoint_out, jerk_active;
   logic [31:0] jerk_num, jerk_div, homing_speed_cmd, homing_accel_cmd, rdata;
   logic [1:0] jerk_segment;
   int bad_count, n_checks;
   // Speeds keep switch search above reference search
   mpu_row_type rows[24] = '{
      '{0, 16'h609A, 8'h00, 32'h0, 32'h000001F4, 0}, '{0, 16'h60A2, 8'h01, 32'h0, 32'h00000001, 0},
      '{0, 16'h60A2, 8'h02, 32'h0, 32'h00000001, 0}, '{0, 16'h60A2, 8'h00, 32'h0, 32'h00000002, 0},
      '{0, 16'h60A4, 8'h01, 32'h0, 32'h000003E8, 0}, '{0, 16'h60A4, 8'h02, 32'h0, 32'h000003E8, 0},
      '{0, 16'h60A4, 8'h03, 32'h0, 32'h000003E8, 0}, '{0, 16'h60A4, 8'h04, 32'h0, 32'h000003E8, 0},
      '{0, 16'h60A8, 8'h00, 32'h0, 32'hFF410000, 0}, '{0, 16'h60A9, 8'h00, 32'h0, 32'h00B44700, 0},
      '{0, 16'h60B0, 8'h00, 32'h0, 32'h00000000, 0}, '{0, 16'h6099, 8'h02, 32'h0, 32'h0000000A, 0},
      '{1, 16'h609A, 8'h00, 32'h00000300, 32'h0, 0}, '{0, 16'h609A, 8'h00, 32'h0, 32'h00000300, 0},
      '{1, 16'h60A2, 8'h00, 32'h00000005, 32'h0, 1}, '{0, 16'h60A2, 8'h00, 32'h0, 32'h00000002, 0},
      '{1, 16'h60A8, 8'h00, 32'h12345678, 32'h0, 0}, '{0, 16'h60A8, 8'h00, 32'h0, 32'h12340000, 0},
      '{1, 16'h60A9, 8'h00, 32'h12345678, 32'h0, 0}, '{0, 16'h60A9, 8'h00, 32'h0, 32'h12345600, 0},
      '{1, 16'h7000, 8'h00, 32'h00000001, 32'h0, 1}, '{0, 16'h7000, 8'h00, 32'h0, 32'h0, 1},
      '{1, 16'h6099, 8'h01, 32'h00000040, 32'h0, 0}, '{1, 16'h6099, 8'h02, 32'h00000008, 32'h0, 0}};
   logic [7:0] seg_sub[4] = '{8'h01, 8'h03, 8'h04, 8'h02};
   logic [31:0] modes[3] = '{32'h00000008, 32'hFFFFFF9C, 32'h00000001};
   logic [31:0] sp_exp[3] = '{32'h000003DE, 32'h000003DE, 32'h000003E8};

   mpu_config dut (.core_clk(core_clk), .resetn(resetn), .obj_index(obj_index), .obj_sub(obj_sub),
      .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
      .obj_err(obj_err), .op_mode(op_mode), .pos_setpoint_in(pos_setpoint_in),
      .pos_setpoint_out(pos_setpoint_out), .jerk_segment(jerk_segment), .jerk_active(jerk_active),
      .jerk_unlimited(jerk_unlimited), .jerk_num(jerk_num), .jerk_div(jerk_div),
      .pos_unit_code(pos_unit_code), .pos_unit_exp(pos_unit_exp), .vel_time_unit(vel_time_unit),
      .vel_pos_unit(vel_pos_unit), .vel_unit_exp(vel_unit_exp), .homing_start(homing_start),
      .homing_switch_pin(homing_switch_pin), .homing_end_pin(homing_end_pin),
      .homing_speed_cmd(homing_speed_cmd), .homing_accel_cmd(homing_accel_cmd),
      .homing_ramp_en(homing_ramp_en), .homing_busy(homing_busy));
   mpu_host_model host (.core_clk(core_clk), .obj_index(obj_index), .obj_sub(obj_sub), .obj_wr(obj_wr),
      .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
      host.access(1'b1, idx, sub, d, 0, rdata, ack, err);
      chk1(ack, 1'b1);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      results();
   end
   initial begin
      {resetn, homing_start, homing_switch_pin, homing_end_pin} = 4'h0;
      {op_mode, pos_setpoint_in, jerk_segment} = {32'h00000001, 32'h000003E8, 2'h0};
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      foreach (rows[i]) begin
         host.access(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd, i % 3, rdata, ack, err);
         chk1(err, rows[i].err);
         if (!rows[i].wr) chk32(rdata, rows[i].rd);
      end
      for (int s = 1; s <= 4; s++) wr(IDX_JERK_LIMITS, 8'(s), 32'h00000100 * s);
      wr(IDX_JERK_FACTOR, SUB_ONE, 32'h00000003);
      wr(IDX_JERK_FACTOR, SUB_TWO, 32'h00000007);
      chk32(jerk_num, 32'h00000003);
      chk32(jerk_div, 32'h00000007);
      chk32({pos_unit_code, pos_unit_exp, vel_time_unit, vel_pos_unit}, 32'h34125634);
      chk32({24'h0, vel_unit_exp}, 32'h00000012);
      for (int s = 0; s < 4; s++) begin
         @(negedge core_clk);
         jerk_segment = 2'(s);
         #1;
         chk32(jerk_active, 32'h00000100 * seg_sub[s]);
         chk1(jerk_unlimited, 1'b0);
      end
      wr(IDX_JERK_LIMITS, SUB_TWO, 32'h00000000);
      chk1(jerk_unlimited, 1'b1);
      // Offset of minus ten applies only in the CSP and clock-direction modes
      wr(IDX_POS_OFFSET, SUB_COUNT, 32'hFFFFFFF6);
      for (int m = 0; m < 3; m++) begin
         @(negedge core_clk);
         op_mode = modes[m];
         @(negedge core_clk);
         chk32(pos_setpoint_out, sp_exp[m]);
      end
      @(negedge core_clk);
      homing_start = 1'b1;
      @(negedge core_clk);
      homing_start = 1'b0;
      chk32(homing_accel_cmd, 32'h00000300);
      chk32(homing_speed_cmd, 32'h00000040);
      chk1(homing_ramp_en & homing_busy, 1'b1);
      @(negedge core_clk);
      chk1(homing_ramp_en, 1'b0);
      homing_switch_pin = 1'b1;
      repeat (3) @(negedge core_clk);
      chk32(homing_speed_cmd, 32'h00000008);
      chk1(homing_ramp_en, 1'b0);
      homing_start = 1'b1;
      @(negedge core_clk);
      homing_start = 1'b0;
      chk1(homing_ramp_en, 1'b0);
      homing_end_pin = 1'b1;
      repeat (3) @(negedge core_clk);
      chk32(homing_speed_cmd, 32'h00000000);
      chk1(homing_busy, 1'b0);
      {homing_switch_pin, homing_end_pin} = 2'b00;
      // Reset after the homing run ends must restore the homing accel and position offset presets
      resetn = 1'b0;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      host.access(1'b0, IDX_HOMING_ACCEL, SUB_COUNT, 32'h0, 0, rdata, ack, err);
      chk32(rdata, 32'h000001F4);
      host.access(1'b0, IDX_POS_OFFSET, SUB_COUNT, 32'h0, 0, rdata, ack, err);
      chk32(rdata, 32'h00000000);
      results();
   end
endmodule
